// File: rtl/cmpe_pkg.sv
// shared constants for the comparator edge control block
package cmpe_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFS_INPUT_SEL = 8'h9f;
  localparam logic [7:0] OFS_CONTROL = 8'h9b;
  localparam logic [7:0] OFS_MODE = 8'h9d;
  localparam logic [7:0] OFS_IRQ_EN = 8'he6;
  localparam logic [7:0] OFS_STATUS = 8'h9c;
  localparam logic [7:0] OFS_MASK = 8'h9e;
  // control register fields
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OUT_BIT = 6;
  localparam int CTL_RIF_BIT = 5;
  localparam int CTL_FIF_BIT = 4;
  localparam int HYP_LSB = 2;
  localparam int HYN_LSB = 0;
  localparam int HYS_W = 2;
  // mode register: response time select and edge masks; then the irq enable register bit
  localparam int MD_RIE_BIT = 5;
  localparam int MD_FIE_BIT = 4;
  localparam int MD_RESP_LSB = 0;
  localparam int MD_RESP_W = 2;
  localparam int IRQ_EN_BIT = 5;
  // input select fields
  localparam int MXN_LSB = 4;
  localparam int MXP_LSB = 0;
  localparam int MX_W = 3;
  localparam logic [7:0] MX_MASK = 8'h77;
  // status bits, same layout in the mask register; then register reset values
  localparam int ST_RISE = 0;
  localparam int ST_FALL = 1;
  localparam int ST_W = 2;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h02;
  localparam logic [7:0] RST_INPUT_SEL = 8'h00;
  localparam logic [1:0] RST_MASK = 2'h3;
  // hysteresis codes
  typedef enum logic [1:0] {
    CMPE_HYS_OFF = 2'h0,
    CMPE_HYS_5MV = 2'h1,
    CMPE_HYS_10MV = 2'h2,
    CMPE_HYS_20MV = 2'h3
  } cmpe_hys_t;
endpackage

// File: rtl/cmpe_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module cmpe_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic out_ff;
  logic nxt_out;

  always_comb begin
    nxt_stage = {stage_ff[1:0], asyncIn};
    // first stage feeds only the second; act once stages 2 and 3 agree
    nxt_out = (stage_ff[1] == stage_ff[2]) ? stage_ff[2] : out_ff;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage_ff <= 3'h0;
      out_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      out_ff <= nxt_out;
    end
  end

  assign syncOut = out_ff;
endmodule

// File: rtl/cmpe_edge.sv
// edge detector producing one-cycle rise and fall pulses
`timescale 1ns/1ps
module cmpe_edge (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic level,
  output logic risePulse,
  output logic fallPulse
);
  logic last_ff;
  logic nxt_last;

  always_comb begin
    nxt_last = level;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
    end
  end

  assign risePulse = level & ~last_ff;
  assign fallPulse = ~level & last_ff;
endmodule

// File: rtl/cmpe_top.sv
// comparator edge control: registers, edge flags, interrupt
`timescale 1ns/1ps
module cmpe_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic cmpOut,
  output logic cmpEnable,
  output logic [1:0] negHysteresisSel,
  output logic [1:0] posHysteresisSel,
  output logic [1:0] responseSel,
  output logic [2:0] negativeInputSelect,
  output logic [2:0] positiveInputSelect,
  output logic irq
);
  default clocking cmpeCb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic cmpSync;
  logic risePulse;
  logic fallPulse;

  logic [7:0] control_ff;
  logic [7:0] nxt_control;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic [7:0] inputSel_ff;
  logic [7:0] nxt_inputSel;
  logic irqEn_ff;
  logic nxt_irqEn;
  logic [1:0] flags_ff;
  logic [1:0] nxt_flags;
  logic [1:0] mask_ff;
  logic [1:0] nxt_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  cmpe_sync uSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(cmpOut),
    .syncOut(cmpSync)
  );

  cmpe_edge uEdge (
    .clock(clock),
    .rst_n(rst_n),
    .level(cmpSync),
    .risePulse(risePulse),
    .fallPulse(fallPulse)
  );

  // register writes
  always_comb begin
    nxt_control = control_ff;
    nxt_mode = mode_ff;
    nxt_inputSel = inputSel_ff;
    nxt_irqEn = irqEn_ff;
    nxt_mask = mask_ff;
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_CONTROL)) begin
      nxt_control = regWdata;
    end
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_MODE)) begin
      nxt_mode = regWdata;
    end
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_INPUT_SEL)) begin
      nxt_inputSel = regWdata & cmpe_pkg::MX_MASK;
    end
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_IRQ_EN)) begin
      nxt_irqEn = regWdata[cmpe_pkg::IRQ_EN_BIT];
    end
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_MASK)) begin
      nxt_mask = regWdata[cmpe_pkg::ST_W-1:0];
    end
  end

  // edge flags: hardware set wins over software clear
  always_comb begin
    nxt_flags = flags_ff;
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_CONTROL)) begin
      nxt_flags[cmpe_pkg::ST_RISE] = regWdata[cmpe_pkg::CTL_RIF_BIT];
      nxt_flags[cmpe_pkg::ST_FALL] = regWdata[cmpe_pkg::CTL_FIF_BIT];
    end
    if (regWrite && hit(regAddr, cmpe_pkg::OFS_STATUS)) begin
      nxt_flags = flags_ff & ~regWdata[cmpe_pkg::ST_W-1:0];
    end
    if (risePulse) begin
      nxt_flags[cmpe_pkg::ST_RISE] = 1'b1;
    end
    if (fallPulse) begin
      nxt_flags[cmpe_pkg::ST_FALL] = 1'b1;
    end
  end

  // interrupt: either flag under its mask, under the global enable
  // next values throughout, so irq never lags a write to enable or masks
  always_comb begin
    nxt_irq = nxt_irqEn & |(nxt_flags & effMask(nxt_mode, nxt_mask));
  end

  // mode edge masks and mask register are ANDed: an edge is enabled only when both are set
  function automatic logic [1:0] effMask(input logic [7:0] m,
                                          input logic [1:0] k);
    effMask = {m[cmpe_pkg::MD_FIE_BIT] & k[cmpe_pkg::ST_FALL],
               m[cmpe_pkg::MD_RIE_BIT] & k[cmpe_pkg::ST_RISE]};
  endfunction

  // read data: one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = 8'h00;
    if (regRead) begin
      if (hit(regAddr, cmpe_pkg::OFS_CONTROL)) begin
        nxt_rdata = control_ff;
        nxt_rdata[cmpe_pkg::CTL_OUT_BIT] = cmpSync;
        nxt_rdata[cmpe_pkg::CTL_RIF_BIT] = flags_ff[cmpe_pkg::ST_RISE];
        nxt_rdata[cmpe_pkg::CTL_FIF_BIT] = flags_ff[cmpe_pkg::ST_FALL];
      end else if (hit(regAddr, cmpe_pkg::OFS_MODE)) begin
        nxt_rdata = mode_ff;
      end else if (hit(regAddr, cmpe_pkg::OFS_INPUT_SEL)) begin
        nxt_rdata = inputSel_ff;
      end else if (hit(regAddr, cmpe_pkg::OFS_IRQ_EN)) begin
        nxt_rdata[cmpe_pkg::IRQ_EN_BIT] = irqEn_ff;
      end else if (hit(regAddr, cmpe_pkg::OFS_STATUS)) begin
        nxt_rdata[cmpe_pkg::ST_W-1:0] = flags_ff;
      end else if (hit(regAddr, cmpe_pkg::OFS_MASK)) begin
        nxt_rdata[cmpe_pkg::ST_W-1:0] = mask_ff;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control_ff <= cmpe_pkg::RST_CONTROL;
      mode_ff <= cmpe_pkg::RST_MODE;
      inputSel_ff <= cmpe_pkg::RST_INPUT_SEL;
      irqEn_ff <= 1'b0;
      flags_ff <= 2'h0;
      mask_ff <= cmpe_pkg::RST_MASK;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      control_ff <= nxt_control;
      mode_ff <= nxt_mode;
      inputSel_ff <= nxt_inputSel;
      irqEn_ff <= nxt_irqEn;
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign regRdata = rdata_ff;
  assign irq = irq_ff;
  // analog controls straight from registers
  assign cmpEnable = control_ff[cmpe_pkg::CTL_EN_BIT];
  assign negHysteresisSel =
    control_ff[cmpe_pkg::HYN_LSB +: cmpe_pkg::HYS_W];
  assign posHysteresisSel =
    control_ff[cmpe_pkg::HYP_LSB +: cmpe_pkg::HYS_W];
  assign responseSel = mode_ff[cmpe_pkg::MD_RESP_LSB +: cmpe_pkg::MD_RESP_W];
  assign negativeInputSelect =
    inputSel_ff[cmpe_pkg::MXN_LSB +: cmpe_pkg::MX_W];
  assign positiveInputSelect =
    inputSel_ff[cmpe_pkg::MXP_LSB +: cmpe_pkg::MX_W];

  // checks: rule properties on the block's own state and ports
  AST_RISE_SETS: assert property (
    risePulse |=> flags_ff[cmpe_pkg::ST_RISE])
    else $error("rise edge did not set flag");

  AST_FALL_SETS: assert property (
    fallPulse |=> flags_ff[cmpe_pkg::ST_FALL])
    else $error("fall edge did not set flag");

  AST_STICKY: assert property (
    (flags_ff[cmpe_pkg::ST_RISE] && !regWrite)
      |=> flags_ff[cmpe_pkg::ST_RISE])
    else $error("rise flag dropped without write");

  AST_FALL_STICKY: assert property (
    (flags_ff[cmpe_pkg::ST_FALL] && !regWrite)
      |=> flags_ff[cmpe_pkg::ST_FALL])
    else $error("fall flag dropped without write");

  AST_RISE_CLR: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_STATUS
      && regWdata[cmpe_pkg::ST_RISE] && !risePulse)
      |=> !flags_ff[cmpe_pkg::ST_RISE])
    else $error("rise flag not cleared by write");

  AST_IRQ_GATE: assert property (
    !irqEn_ff |-> !irq)
    else $error("irq without enable");

  AST_IRQ_OR: assert property (
    irq == (irqEn_ff & |(flags_ff & effMask(mode_ff, mask_ff))))
    else $error("irq not flag and mask");

  AST_RISE_MASK: assert property (
    (irq && !flags_ff[cmpe_pkg::ST_FALL]) |-> mode_ff[cmpe_pkg::MD_RIE_BIT])
    else $error("rise irq while masked");

  AST_FALL_MASK: assert property (
    (irq && !flags_ff[cmpe_pkg::ST_RISE]) |-> mode_ff[cmpe_pkg::MD_FIE_BIT])
    else $error("fall irq while masked");

  AST_NO_MASK: assert property (
    (effMask(mode_ff, mask_ff) == 2'h0) |-> !irq)
    else $error("irq with both edges masked");

  AST_RISE_IRQ: assert property (
    (risePulse && irqEn_ff && mode_ff[cmpe_pkg::MD_RIE_BIT]
      && mask_ff[cmpe_pkg::ST_RISE] && !regWrite) |=> irq)
    else $error("rise edge raised no irq");

  AST_FALL_IRQ: assert property (
    (fallPulse && irqEn_ff && mode_ff[cmpe_pkg::MD_FIE_BIT]
      && mask_ff[cmpe_pkg::ST_FALL] && !regWrite) |=> irq)
    else $error("fall edge raised no irq");

  AST_MX_ZERO: assert property (
    inputSel_ff[7] == 1'b0 && inputSel_ff[3] == 1'b0)
    else $error("unused select bits set");

  AST_MX_READ: assert property (
    (regRead && regAddr == cmpe_pkg::OFS_INPUT_SEL)
      |=> (!regRdata[7] && !regRdata[3]))
    else $error("unused select bits read back set");

  AST_MXN_WRITE: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_INPUT_SEL) |=> negativeInputSelect
      == $past(regWdata[cmpe_pkg::MXN_LSB +: cmpe_pkg::MX_W]))
    else $error("negative input select not taken");

  AST_MXP_WRITE: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_INPUT_SEL) |=> positiveInputSelect
      == $past(regWdata[cmpe_pkg::MXP_LSB +: cmpe_pkg::MX_W]))
    else $error("positive input select not taken");

  AST_EN_WRITE: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_CONTROL)
      |=> cmpEnable == $past(regWdata[cmpe_pkg::CTL_EN_BIT]))
    else $error("enable not taken");

  AST_HYN_WRITE: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_CONTROL) |=> negHysteresisSel
      == $past(regWdata[cmpe_pkg::HYN_LSB +: cmpe_pkg::HYS_W]))
    else $error("negative hysteresis not taken");

  AST_HYP_WRITE: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_CONTROL) |=> posHysteresisSel
      == $past(regWdata[cmpe_pkg::HYP_LSB +: cmpe_pkg::HYS_W]))
    else $error("positive hysteresis not taken");

  AST_HYS_HOLD: assert property (
    (regWrite && regAddr != cmpe_pkg::OFS_CONTROL)
      |=> $stable({posHysteresisSel, negHysteresisSel}))
    else $error("hysteresis changed by another register");

  AST_RESP_WRITE: assert property (
    (regWrite && regAddr == cmpe_pkg::OFS_MODE) |=> responseSel
      == $past(regWdata[cmpe_pkg::MD_RESP_LSB +: cmpe_pkg::MD_RESP_W]))
    else $error("response time not taken");

  AST_OUT_READ: assert property (
    (regRead && regAddr == cmpe_pkg::OFS_CONTROL)
      |=> regRdata[cmpe_pkg::CTL_OUT_BIT] == $past(cmpSync))
    else $error("output bit wrong");

  AST_SYNC_EDGE: assert property (
    risePulse |=> !risePulse)
    else $error("double rise pulse");

  AST_FALL_ONCE: assert property (
    fallPulse |=> !fallPulse)
    else $error("double fall pulse");

  AST_ONE_EDGE: assert property (
    !(risePulse && fallPulse))
    else $error("rise and fall pulse together");
endmodule

// File: bench/cmpe_cmp_model.sv
// behavioural analog comparator core with its input pins
`timescale 1ns/1ps
module cmpe_cmp_model (
  input wire logic cmpEnable,
  input wire logic [2:0] negativeInputSelect,
  input wire logic [2:0] positiveInputSelect,
  input wire logic analogHigh,
  output logic cmpOut
);
  // unpowered core or open input pulls the output low
  assign cmpOut = cmpEnable & ~negativeInputSelect[2]
    & ~positiveInputSelect[2] & analogHigh;
endmodule

// File: bench/cmpe_top_tb.sv
// self-checking bench for the comparator edge control block
`timescale 1ns/1ps
module cmpe_top_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic cmpOut, cmpEnable, irq, analogHigh = 1'b0;
  logic [1:0] negHysteresisSel, posHysteresisSel, responseSel;
  logic [2:0] negativeInputSelect, positiveInputSelect;
  logic [7:0] i;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  cmpe_top u_cmpe_top (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .cmpOut(cmpOut), .cmpEnable(cmpEnable),
    .negHysteresisSel(negHysteresisSel),
    .posHysteresisSel(posHysteresisSel), .responseSel(responseSel),
    .negativeInputSelect(negativeInputSelect),
    .positiveInputSelect(positiveInputSelect), .irq(irq));
  cmpe_cmp_model u_cmpe_cmp_model (.cmpEnable(cmpEnable),
    .negativeInputSelect(negativeInputSelect),
    .positiveInputSelect(positiveInputSelect),
    .analogHigh(analogHigh), .cmpOut(cmpOut));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // tests take about 150 cycles; the ceiling leaves ample slack
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    // one edge passes: no double strobe drive, outputs settle before checks
    @(posedge clock);
  endtask
  // read data stand only in the cycle after the strobe: look mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    checks = checks + 1;
    if (regRdata !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t reg %h got %h exp %h", $time, a, regRdata, exp);
    end
    @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    @(negedge clock);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t port got %h exp %h", $time, got, exp);
    end
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  initial begin
    idle(4);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(cmpe_pkg::OFS_CONTROL, 8'h00);
    rd(cmpe_pkg::OFS_MODE, 8'h02);
    rd(cmpe_pkg::OFS_INPUT_SEL, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");
    wr(cmpe_pkg::OFS_INPUT_SEL, 8'hff);
    rd(cmpe_pkg::OFS_INPUT_SEL, 8'h77);
    chk({5'h0, negativeInputSelect}, 8'h07);
    wr(cmpe_pkg::OFS_INPUT_SEL, 8'h10);
    rd(cmpe_pkg::OFS_INPUT_SEL, 8'h10);
    chk({5'h0, negativeInputSelect}, 8'h01);
    chk({5'h0, positiveInputSelect}, 8'h00);
    $display("test input select done");
    for (i = 8'h00; i < 8'h04; i++) begin
      wr(cmpe_pkg::OFS_CONTROL, 8'h80 | (i << 2) | i);
      chk({6'h0, negHysteresisSel}, i);
      chk({6'h0, posHysteresisSel}, i);
      chk({7'h0, cmpEnable}, 8'h01);
      wr(cmpe_pkg::OFS_MODE, i);
      chk({6'h0, responseSel}, i);
    end
    $display("test config done");
    wr(cmpe_pkg::OFS_MODE, 8'h02);
    wr(cmpe_pkg::OFS_STATUS, 8'h03);
    analogHigh <= 1'b1;
    idle(10);
    rd(cmpe_pkg::OFS_CONTROL, 8'hef);
    chk({7'h0, irq}, 8'h00);
    wr(cmpe_pkg::OFS_MODE, 8'h32);
    wr(cmpe_pkg::OFS_IRQ_EN, 8'h20);
    idle(2);
    chk({7'h0, irq}, 8'h01);
    rd(cmpe_pkg::OFS_STATUS, 8'h01);
    rd(cmpe_pkg::OFS_IRQ_EN, 8'h20);
    rd(cmpe_pkg::OFS_MASK, 8'h03);
    wr(cmpe_pkg::OFS_MASK, 8'h02);
    chk({7'h0, irq}, 8'h00);
    wr(cmpe_pkg::OFS_MASK, 8'h03);
    chk({7'h0, irq}, 8'h01);
    wr(cmpe_pkg::OFS_IRQ_EN, 8'h00);
    idle(2);
    chk({7'h0, irq}, 8'h00);
    wr(cmpe_pkg::OFS_IRQ_EN, 8'h20);
    idle(20);
    rd(cmpe_pkg::OFS_CONTROL, 8'hef);
    wr(cmpe_pkg::OFS_STATUS, 8'h01);
    idle(2);
    chk({7'h0, irq}, 8'h00);
    $display("test rising edge done");
    analogHigh <= 1'b0;
    idle(10);
    rd(cmpe_pkg::OFS_CONTROL, 8'h9f);
    chk({7'h0, irq}, 8'h01);
    wr(cmpe_pkg::OFS_MODE, 8'h22);
    idle(2);
    chk({7'h0, irq}, 8'h00);
    wr(cmpe_pkg::OFS_CONTROL, 8'h00);
    rd(cmpe_pkg::OFS_CONTROL, 8'h00);
    chk({7'h0, cmpEnable}, 8'h00);
    $display("test falling edge done");
    report_and_stop();
  end
endmodule
